// ### ppwdr_top.sv
// Our own choices: the placing of the registers and the APB register port.
`timescale 1ns/1ns
module ppwdr_top import ppwdr_pkg::*; #(
	parameter bit LARGE_VARIANT = 1'b1
) (
	input  wire logic        MCLK,
	input  wire logic        SRST,
	input  wire logic        PSEL,
	input  wire logic        PENABLE,
	input  wire logic        PWRITE,
	input  wire logic [7:0]  PADDR,
	input  wire logic [31:0] PWDATA,
	output logic      [31:0] PRDATA,
	output logic             PREADY,
	output logic             PSLVERR,
	input  wire logic [7:0]  PA_IN,
	output logic      [7:0]  PA_OUT,
	output logic      [7:0]  PA_OE_N,
	output logic      [7:0]  PA_PULLUP,
	input  wire logic [7:0]  PB_IN,
	output logic      [7:0]  PB_OUT,
	output logic      [7:0]  PB_OE_N,
	output logic      [7:0]  PB_PULLUP,
	input  wire logic [7:0]  PC_IN,
	output logic      [7:0]  PC_OUT,
	output logic      [7:0]  PC_OE_N,
	output logic      [7:0]  PC_PULLUP,
	input  wire logic [7:0]  PD_IN,
	output logic      [7:0]  PD_OUT,
	output logic      [7:0]  PD_OE_N,
	output logic      [7:0]  PD_PULLUP,
	input  wire logic [5:0]  PE_IN,
	output logic      [5:0]  PE_OUT,
	output logic      [5:0]  PE_OE_N,
	output logic      [5:0]  PE_PULLUP,
	input  wire logic        HALTED,
	output logic             WAKE,
	output logic             SERIAL_CHIP_SELECT,
	output logic             SERIAL_DATA_IN,
	output logic             SERIAL_CLOCK,
	output logic             EXT_IRQ1,
	output logic             EXT_IRQ0,
	output logic             TIMER1_CLOCK_IN,
	output logic             TIMER0_CLOCK_IN,
	output logic             PERIPH_IRQ_PIN,
	input  wire logic        SERIAL_DATA_OUT,
	input  wire logic        PERIPH_CLOCK_PIN
);
	////////////////////////////////////////////////////////////////////////////
	// Helpers
	function automatic ppwdr_byte_t port_mask(input int p);
		port_mask = (p == PORT_E) ? SIX_MASK : FULL_MASK;
	endfunction

	// Returns {valid, index}
	function automatic logic [5:0] reg_dec(input logic [7:0] a);
		logic ok;
		ok      = (a[1:0] == 2'h0) && !a[7] && (a[6:2] <= REG_IRQ_CLOCK_PIN_LOCATION_REG);
		reg_dec = {ok, a[6:2]};
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// State
	ppwdr_byte_t data_r  [NPORT];
	ppwdr_byte_t data_nxt[NPORT];
	ppwdr_byte_t dir_r   [NPORT];
	ppwdr_byte_t dir_nxt [NPORT];
	ppwdr_byte_t pu_r    [NPORT];
	ppwdr_byte_t pu_nxt  [NPORT];
	ppwdr_byte_t wake_en_r;
	ppwdr_byte_t wake_en_nxt;
	ppwdr_byte_t serial_pin_location_large_r;
	ppwdr_byte_t serial_pin_location_large_nxt;
	ppwdr_byte_t irq_clock_pin_location_reg_r;
	ppwdr_byte_t irq_clock_pin_location_reg_nxt;
	logic        pready_r;
	logic        pready_nxt;
	logic        pslverr_r;
	logic        pslverr_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic [39:0] pin_out_r;
	logic [39:0] pin_out_nxt;
	logic [39:0] pullup_r;
	logic [39:0] pullup_nxt;
	logic [7:0]  func_in_r;
	logic [7:0]  func_in_nxt;

	ppwdr_byte_t port_rd[NPORT];
	logic [5:0]  wdec;
	logic [5:0]  rdec;
	logic        wr_go;
	logic [1:0]  loc_code[NFUNC];
	logic        loc_ok  [NFUNC];
	ppwdr_pin_t  loc_pin [NFUNC];
	ppwdr_byte_t serial_pin_location_large_mask;
	ppwdr_byte_t irq_clock_pin_location_reg_mask;

	ppwdr_pin_if pins();

	////////////////////////////////////////////////////////////////////////////
	// Pin input synchroniser and wake-up
	ppwdr_sync u_sync (
		.clk  (MCLK),
		.srst (SRST),
		.raw  ({2'h0, PE_IN, PD_IN, PC_IN, PB_IN, PA_IN}),
		.pins (pins)
	);

	ppwdr_wake u_wake (
		.clk     (MCLK),
		.srst    (SRST),
		.pins    (pins),
		.wake_en (wake_en_r),
		.halted  (HALTED),
		.wake    (WAKE)
	);

	////////////////////////////////////////////////////////////////////////////
	// Pin location selectors
	assign serial_pin_location_large_mask = LARGE_VARIANT ? FULL_MASK : SERIAL_PIN_LOCATION_LARGE_MASK_SM;
	assign irq_clock_pin_location_reg_mask = LARGE_VARIANT ? FULL_MASK : IRQ_CLOCK_PIN_LOCATION_REG_MASK_SM;

	for (genvar f = 0; f < NFUNC; f++) begin : g_loc
		ppwdr_byte_t src;
		assign src = FLD_IRQ_CLOCK_PIN_LOCATION_REG[f] ? irq_clock_pin_location_reg_r : serial_pin_location_large_r;
		if (FLD_WIDE[f]) begin : g_wide
			assign loc_code[f] = src[FLD_LSB[f] +: 2];
		end else begin : g_bit
			// Single-bit fields only reach codes 0 and 1
			assign loc_code[f] = {1'b0, src[FLD_LSB[f]]};
		end
		assign loc_ok[f]  = (loc_code[f] != LOC_UNDEF);
		assign loc_pin[f] = LOC_TBL[f][loc_code[f]];
	end

	////////////////////////////////////////////////////////////////////////////
	// Register writes
	assign wdec  = reg_dec(PADDR);
	assign rdec  = wdec;
	assign wr_go = PSEL && PENABLE && PWRITE && pready_r && wdec[5];

	always_comb begin
		wake_en_nxt = wake_en_r;
		serial_pin_location_large_nxt    = serial_pin_location_large_r;
		irq_clock_pin_location_reg_nxt    = irq_clock_pin_location_reg_r;
		for (int p = 0; p < NPORT; p++) begin
			data_nxt[p] = data_r[p];
			dir_nxt[p]  = dir_r[p];
			pu_nxt[p]   = pu_r[p];
			if (wr_go && wdec[4:0] == REG_DATA + 5'(p)) begin
				data_nxt[p] = PWDATA[7:0] & port_mask(p);
			end
			if (wr_go && wdec[4:0] == REG_DIR + 5'(p)) begin
				dir_nxt[p] = PWDATA[7:0] & port_mask(p);
			end
			if (wr_go && wdec[4:0] == REG_PU + 5'(p)) begin
				pu_nxt[p] = PWDATA[7:0] & port_mask(p);
			end
		end
		if (wr_go && wdec[4:0] == REG_WAKE) begin
			wake_en_nxt = PWDATA[7:0];
		end
		if (wr_go && wdec[4:0] == REG_SERIAL_PIN_LOCATION_LARGE) begin
			serial_pin_location_large_nxt = PWDATA[7:0] & serial_pin_location_large_mask;
		end
		if (wr_go && wdec[4:0] == REG_IRQ_CLOCK_PIN_LOCATION_REG) begin
			irq_clock_pin_location_reg_nxt = PWDATA[7:0] & irq_clock_pin_location_reg_mask;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			for (int p = 0; p < NPORT; p++) begin
				data_r[p] <= (p == PORT_E) ? DATA_RST_SIX : DATA_RST_FULL;
				dir_r[p]  <= (p == PORT_E) ? DIR_RST_SIX : DIR_RST_FULL;
				pu_r[p]   <= PU_RST;
			end
			wake_en_r <= WAKE_RST;
			serial_pin_location_large_r    <= PRM_RST;
			irq_clock_pin_location_reg_r    <= PRM_RST;
		end else begin
			for (int p = 0; p < NPORT; p++) begin
				data_r[p] <= data_nxt[p];
				dir_r[p]  <= dir_nxt[p];
				pu_r[p]   <= pu_nxt[p];
			end
			wake_en_r <= wake_en_nxt;
			serial_pin_location_large_r    <= serial_pin_location_large_nxt;
			irq_clock_pin_location_reg_r    <= irq_clock_pin_location_reg_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Register reads and APB answer
	always_comb begin
		for (int p = 0; p < NPORT; p++) begin
			// Input pins show the live level, output pins the latch
			port_rd[p] = ((dir_r[p] & pins.lvl[p*8 +: 8])
				| (~dir_r[p] & data_r[p])) & port_mask(p);
		end
	end

	always_comb begin
		pready_nxt  = PSEL && !PENABLE;
		pslverr_nxt = pslverr_r;
		prdata_nxt  = prdata_r;
		if (PSEL && !PENABLE) begin
			pslverr_nxt = !rdec[5];
			prdata_nxt  = 32'h0;
			if (!PWRITE && rdec[5]) begin
				for (int p = 0; p < NPORT; p++) begin
					if (rdec[4:0] == REG_DATA + 5'(p)) prdata_nxt[7:0] = port_rd[p];
					if (rdec[4:0] == REG_DIR + 5'(p)) prdata_nxt[7:0] = dir_r[p];
					if (rdec[4:0] == REG_PU + 5'(p)) prdata_nxt[7:0] = pu_r[p];
				end
				if (rdec[4:0] == REG_WAKE) prdata_nxt[7:0] = wake_en_r;
				if (rdec[4:0] == REG_SERIAL_PIN_LOCATION_LARGE) prdata_nxt[7:0] = serial_pin_location_large_r;
				if (rdec[4:0] == REG_IRQ_CLOCK_PIN_LOCATION_REG) prdata_nxt[7:0] = irq_clock_pin_location_reg_r;
			end
		end else if (PSEL && PENABLE && pready_r) begin
			pslverr_nxt = 1'b0;
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			pready_r  <= 1'b0;
			pslverr_r <= 1'b0;
			prdata_r  <= 32'h0;
		end else begin
			pready_r  <= pready_nxt;
			pslverr_r <= pslverr_nxt;
			prdata_r  <= prdata_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Pin drive, pull-high and function routing
	always_comb begin
		func_in_nxt = 8'h0;
		for (int p = 0; p < NPORT; p++) begin
			pin_out_nxt[p*8 +: 8] = data_r[p];
			pullup_nxt[p*8 +: 8]  = dir_r[p] & pu_r[p];
		end
		// Output functions take over the latch on their selected pin
		if (loc_ok[F_SDO]) pin_out_nxt[loc_pin[F_SDO]] = SERIAL_DATA_OUT;
		if (loc_ok[F_PCK]) pin_out_nxt[loc_pin[F_PCK]] = PERIPH_CLOCK_PIN;
		// Undefined codes leave the function input low
		for (int f = 0; f < F_SDO; f++) begin
			func_in_nxt[f] = loc_ok[f] && pins.lvl[loc_pin[f]];
		end
	end

	always_ff @(posedge MCLK) begin
		if (SRST) begin
			pin_out_r <= '0;
			pullup_r  <= '0;
			func_in_r <= 8'h0;
		end else begin
			pin_out_r <= pin_out_nxt;
			pullup_r  <= pullup_nxt;
			func_in_r <= func_in_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Outputs
	assign PRDATA             = prdata_r;
	assign PREADY             = pready_r;
	assign PSLVERR            = pslverr_r;
	assign PA_OUT             = pin_out_r[7:0];
	assign PB_OUT             = pin_out_r[15:8];
	assign PC_OUT             = pin_out_r[23:16];
	assign PD_OUT             = pin_out_r[31:24];
	assign PE_OUT             = pin_out_r[37:32];
	assign PA_OE_N            = dir_r[0];
	assign PB_OE_N            = dir_r[1];
	assign PC_OE_N            = dir_r[2];
	assign PD_OE_N            = dir_r[3];
	assign PE_OE_N            = dir_r[4][5:0];
	assign PA_PULLUP          = pullup_r[7:0];
	assign PB_PULLUP          = pullup_r[15:8];
	assign PC_PULLUP          = pullup_r[23:16];
	assign PD_PULLUP          = pullup_r[31:24];
	assign PE_PULLUP          = pullup_r[37:32];
	assign SERIAL_CHIP_SELECT = func_in_r[F_CS];
	assign SERIAL_DATA_IN     = func_in_r[F_SDI];
	assign SERIAL_CLOCK       = func_in_r[F_SCK];
	assign EXT_IRQ1           = func_in_r[F_EXT_IRQ1];
	assign EXT_IRQ0           = func_in_r[F_EXT_IRQ0];
	assign TIMER1_CLOCK_IN    = func_in_r[F_TIMER1_CLOCK_IN];
	assign TIMER0_CLOCK_IN    = func_in_r[F_TIMER0_CLOCK_IN];
	assign PERIPH_IRQ_PIN     = func_in_r[F_PERIPH_IRQ_PIN];

	////////////////////////////////////////////////////////////////////////////
	// Checks
	AST_PU_INPUT_ONLY: assert property (@(posedge MCLK) disable iff (SRST)
		(!dir_r[0][0] || !pu_r[0][0]) |=> !PA_PULLUP[0])
		else $error("Pull-high on output or disabled pin");
	AST_RESET_VALUES: assert property (@(posedge MCLK) disable iff (SRST)
		$past(SRST) |-> dir_r[0] == 8'hff && dir_r[4] == 8'h0f && pu_r[0] == 8'h00
		&& wake_en_r == 8'h00)
		else $error("Wrong register value after reset");
	AST_SIX_UPPER_ZERO: assert property (@(posedge MCLK) disable iff (SRST)
		dir_r[4][7:6] == 2'h0 && pu_r[4][7:6] == 2'h0)
		else $error("Six-pin port upper bits set");
	AST_READ_LATCH: assert property (@(posedge MCLK) disable iff (SRST)
		(PSEL && !PENABLE && !PWRITE && PADDR == 8'h00)
		|=> (PRDATA[7:0] & ~$past(dir_r[0])) == ($past(data_r[0]) & ~$past(dir_r[0])))
		else $error("Output pin read did not return latch");
	AST_READ_PIN: assert property (@(posedge MCLK) disable iff (SRST)
		(PSEL && !PENABLE && !PWRITE && PADDR == 8'h00)
		|=> (PRDATA[7:0] & $past(dir_r[0])) == ($past(pins.lvl[7:0]) & $past(dir_r[0])))
		else $error("Input pin read did not return pin level");
	AST_DIR_WRITE: assert property (@(posedge MCLK) disable iff (SRST)
		(PSEL && PENABLE && PWRITE && PREADY && PADDR == 8'h14)
		|=> dir_r[0] == $past(PWDATA[7:0]) ##1 PA_OE_N == $past(PWDATA[7:0], 2))
		else $error("Direction write not applied");
	AST_SDO_ROUTE: assert property (@(posedge MCLK) disable iff (SRST)
		(serial_pin_location_large_r[1:0] == 2'h0) |=> PA_OUT[7] == $past(SERIAL_DATA_OUT))
		else $error("Data-out not routed to port A bit 7");
	AST_CS_UNDEF: assert property (@(posedge MCLK) disable iff (SRST)
		(serial_pin_location_large_r[7:6] == 2'h3) |=> !SERIAL_CHIP_SELECT)
		else $error("Undefined chip-select code still connected");
	AST_APB_READY: assert property (@(posedge MCLK) disable iff (SRST)
		(PSEL && !PENABLE) |=> PREADY ##1 !PREADY)
		else $error("Ready not given in first access cycle");
	AST_SLVERR_MISALIGN: assert property (@(posedge MCLK) disable iff (SRST)
		(PSEL && !PENABLE && PADDR[1:0] != 2'h0) |=> PSLVERR)
		else $error("Misaligned access gave no error response");
	AST_PCK_ROUTE: assert property (@(posedge MCLK) disable iff (SRST)
		(irq_clock_pin_location_reg_r[1:0] == 2'h0) |=> PB_OUT[4] == $past(PERIPH_CLOCK_PIN))
		else $error("Peripheral clock not routed to port B bit 4");
	AST_SDI_ROUTE: assert property (@(posedge MCLK) disable iff (SRST)
		(serial_pin_location_large_r[5:4] == 2'h1) |=> SERIAL_DATA_IN == $past(pins.lvl[18]))
		else $error("Data-in not taken from port C bit 2");
	AST_SDO_UNDEF: assert property (@(posedge MCLK) disable iff (SRST)
		(serial_pin_location_large_r[1:0] == 2'h3) |=> PA_OUT[7] == $past(data_r[0][7]))
		else $error("Undefined data-out code still drives port A bit 7");
	AST_PU_SIX_PIN: assert property (@(posedge MCLK) disable iff (SRST)
		PE_PULLUP == $past(dir_r[4][5:0] & pu_r[4][5:0]))
		else $error("Six-pin port pull-high not input and enable");
endmodule // ppwdr_top

// ### ppwdr_pkg.sv
////////////////////////////////////////////////////////////////////////////////
// What this block does
// - Pull-high only on input pins with enable
// - Eight-bit pull-high enables, all reset zero
// - Six-pin ports: pull-high bits 5..0, upper zero
// - Port A falling edge wakes halted device
// - Eight-bit Port A wake enables, reset zero
// - Direction one: input, read pin level
// - Direction zero: CMOS output from latch
// - Output pins read back the latch
// - Direction writable anytime, effective immediately
// - Full-port direction bits reset to input
// - Six-pin direction: 5,4 output, 3..0 input
// - Chip-select location: A3, C3, E2
// - Data-in location: A0, C2, E4
// - Serial clock location: A2, C1, E3
// - Small variant: one-bit serial selectors, A/C
// - Inputs sampled live, output latch holds
package ppwdr_pkg;
	localparam int NPORT  = 5;
	localparam int NPIN   = 40;
	localparam int NFUNC  = 10;
	localparam int PORT_E = 4;

	typedef logic [7:0] ppwdr_byte_t;
	typedef logic [5:0] ppwdr_pin_t;

	// Register index; byte address is index times four
	localparam logic [4:0] REG_DATA = 5'h00;
	localparam logic [4:0] REG_DIR  = 5'h05;
	localparam logic [4:0] REG_PU   = 5'h0a;
	localparam logic [4:0] REG_WAKE = 5'h0f;
	localparam logic [4:0] REG_SERIAL_PIN_LOCATION_LARGE = 5'h10;
	localparam logic [4:0] REG_IRQ_CLOCK_PIN_LOCATION_REG = 5'h11;

	localparam ppwdr_byte_t FULL_MASK     = 8'hff;
	localparam ppwdr_byte_t SIX_MASK      = 8'h3f;
	localparam ppwdr_byte_t DIR_RST_FULL  = 8'hff;
	localparam ppwdr_byte_t DIR_RST_SIX   = 8'h0f;
	localparam ppwdr_byte_t DATA_RST_FULL = 8'hff;
	localparam ppwdr_byte_t DATA_RST_SIX  = 8'h3f;
	localparam ppwdr_byte_t PU_RST        = 8'h00;
	localparam ppwdr_byte_t WAKE_RST      = 8'h00;
	localparam ppwdr_byte_t PRM_RST       = 8'h00;
	localparam ppwdr_byte_t SERIAL_PIN_LOCATION_LARGE_MASK_SM  = 8'h55;
	localparam ppwdr_byte_t IRQ_CLOCK_PIN_LOCATION_REG_MASK_SM  = 8'hf5;

	// Remapped functions
	localparam int F_CS   = 0;
	localparam int F_SDI  = 1;
	localparam int F_SCK  = 2;
	localparam int F_EXT_IRQ1 = 3;
	localparam int F_EXT_IRQ0 = 4;
	localparam int F_TIMER1_CLOCK_IN = 5;
	localparam int F_TIMER0_CLOCK_IN = 6;
	localparam int F_PERIPH_IRQ_PIN = 7;
	localparam int F_SDO  = 8;
	localparam int F_PCK  = 9;

	// Selector field layout per function
	localparam int FLD_LSB  [NFUNC] = '{6, 4, 2, 7, 6, 5, 4, 2, 0, 0};
	localparam bit FLD_WIDE [NFUNC] = '{1, 1, 1, 0, 0, 0, 0, 1, 1, 1};
	localparam bit FLD_IRQ_CLOCK_PIN_LOCATION_REG [NFUNC] = '{0, 0, 0, 1, 1, 1, 1, 1, 0, 1};
	localparam logic [1:0] LOC_UNDEF = 2'h3;

	// Pin index is port times eight plus bit, per selector code
	localparam ppwdr_pin_t LOC_TBL [NFUNC][4] = '{
		'{6'h03, 6'h13, 6'h22, 6'h00},
		'{6'h00, 6'h12, 6'h24, 6'h00},
		'{6'h02, 6'h11, 6'h23, 6'h00},
		'{6'h01, 6'h15, 6'h00, 6'h00},
		'{6'h04, 6'h14, 6'h00, 6'h00},
		'{6'h01, 6'h15, 6'h00, 6'h00},
		'{6'h04, 6'h14, 6'h00, 6'h00},
		'{6'h0d, 6'h17, 6'h20, 6'h00},
		'{6'h07, 6'h10, 6'h25, 6'h00},
		'{6'h0c, 6'h16, 6'h21, 6'h00}
	};
endpackage

// ### ppwdr_pin_if.sv
`timescale 1ns/1ns
interface ppwdr_pin_if;
	logic [39:0] lvl;
	modport src (output lvl);
	modport snk (input lvl);
endinterface // ppwdr_pin_if

// ### ppwdr_sync.sv
`timescale 1ns/1ns
module ppwdr_sync import ppwdr_pkg::*; (
	input  wire logic        clk,
	input  wire logic        srst,
	input  wire logic [39:0] raw,
	ppwdr_pin_if.src         pins
);
	logic [39:0] s1_r;
	logic [39:0] s1_nxt;
	logic [39:0] s2_r;
	logic [39:0] s2_nxt;

	always_comb begin
		s1_nxt = raw;
		s2_nxt = s1_r;
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			s1_r <= '0;
			s2_r <= '0;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
		end
	end

	assign pins.lvl = s2_r;
endmodule // ppwdr_sync

// ### ppwdr_wake.sv
`timescale 1ns/1ns
module ppwdr_wake import ppwdr_pkg::*; (
	input  wire logic        clk,
	input  wire logic        srst,
	ppwdr_pin_if.snk         pins,
	input  wire ppwdr_byte_t wake_en,
	input  wire logic        halted,
	output logic             wake
);
	ppwdr_byte_t prev_r;
	ppwdr_byte_t prev_nxt;
	logic        wake_r;
	logic        wake_nxt;
	ppwdr_byte_t fall;

	always_comb begin
		prev_nxt = pins.lvl[7:0];
		fall     = prev_r & ~pins.lvl[7:0] & wake_en;
		wake_nxt = halted & (|fall);
	end

	always_ff @(posedge clk) begin
		if (srst) begin
			prev_r <= '0;
			wake_r <= 1'b0;
		end else begin
			prev_r <= prev_nxt;
			wake_r <= wake_nxt;
		end
	end

	assign wake = wake_r;

	AST_WAKE_ON_FALL: assert property (@(posedge clk) disable iff (srst)
		(halted && |(prev_r & ~pins.lvl[7:0] & wake_en)) |=> wake)
		else $error("Enabled falling edge while halted gave no wake");
	AST_WAKE_CAUSE: assert property (@(posedge clk) disable iff (srst)
		wake |-> $past(halted) && |($past(prev_r) & ~$past(pins.lvl[7:0])))
		else $error("Wake without halted falling edge");
endmodule // ppwdr_wake

// ### ppwdr_switch_model.sv
`timescale 1ns/1ns
module ppwdr_switch_model (
	input  wire logic        clk,
	input  wire logic [39:0] drv,
	input  wire logic [39:0] oe_n,
	input  wire logic [39:0] pu_en,
	input  wire logic [39:0] sw_en,
	input  wire logic [39:0] sw_lvl,
	output logic      [39:0] pin
);
	// Undriven, unpulled pins wander every cycle
	logic [39:0] float_r = 40'h0;
	always @(posedge clk) begin
		float_r <= ~float_r;
	end
	always_comb begin
		for (int i = 0; i < 40; i++) begin
			if (!oe_n[i]) begin
				pin[i] = drv[i];
			end else if (sw_en[i]) begin
				pin[i] = sw_lvl[i];
			end else if (pu_en[i]) begin
				pin[i] = 1'b1;
			end else begin
				pin[i] = float_r[i];
			end
		end
	end
endmodule // ppwdr_switch_model

// ### tb.sv
`timescale 1ns/1ns
module tb import ppwdr_pkg::*;;
	localparam int EXP [8][3] = '{'{3, 19, 34}, '{0, 18, 36}, '{2, 17, 35}, '{1, 21, 1},
		'{4, 20, 4}, '{1, 21, 1}, '{4, 20, 4}, '{13, 23, 32}};
	logic        mclk    = 1'b0;
	logic        srst    = 1'b1;
	logic        psel    = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite  = 1'b0;
	logic [7:0]  paddr   = 8'h00;
	logic [31:0] pwdata  = 32'h0;
	logic        halted  = 1'b0;
	logic        serial_data_out     = 1'b0;
	logic        periph_clock_pin     = 1'b0;
	logic [39:0] sw_en   = 40'h0;
	logic [39:0] sw_lvl  = 40'h0;
	logic [7:0]  bad [3] = '{8'h02, 8'h48, 8'h80};
	wire  [31:0] prdata;
	wire         pready;
	wire         pslverr;
	wire         wake;
	wire  [7:0]  fo;
	wire  [39:0] drv;
	wire  [39:0] oe_n;
	wire  [39:0] pu;
	wire  [39:0] pin;
	int          num_errors = 0;
	int          n_compared = 0;
	int          cyc        = 0;
	int          wk;
	logic [31:0] rd;
	logic        er;

	assign drv[39:38]  = 2'b00;
	assign oe_n[39:38] = 2'b11;
	assign pu[39:38]   = 2'b00;

	ppwdr_top #(.LARGE_VARIANT(1'b1)) uut (
		.MCLK(mclk), .SRST(srst), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
		.PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
		.PA_IN(pin[7:0]), .PA_OUT(drv[7:0]), .PA_OE_N(oe_n[7:0]), .PA_PULLUP(pu[7:0]),
		.PB_IN(pin[15:8]), .PB_OUT(drv[15:8]), .PB_OE_N(oe_n[15:8]), .PB_PULLUP(pu[15:8]),
		.PC_IN(pin[23:16]), .PC_OUT(drv[23:16]), .PC_OE_N(oe_n[23:16]), .PC_PULLUP(pu[23:16]),
		.PD_IN(pin[31:24]), .PD_OUT(drv[31:24]), .PD_OE_N(oe_n[31:24]), .PD_PULLUP(pu[31:24]),
		.PE_IN(pin[37:32]), .PE_OUT(drv[37:32]), .PE_OE_N(oe_n[37:32]), .PE_PULLUP(pu[37:32]),
		.HALTED(halted), .WAKE(wake), .SERIAL_CHIP_SELECT(fo[0]), .SERIAL_DATA_IN(fo[1]),
		.SERIAL_CLOCK(fo[2]), .EXT_IRQ1(fo[3]), .EXT_IRQ0(fo[4]), .TIMER1_CLOCK_IN(fo[5]),
		.TIMER0_CLOCK_IN(fo[6]), .PERIPH_IRQ_PIN(fo[7]), .SERIAL_DATA_OUT(serial_data_out),
		.PERIPH_CLOCK_PIN(periph_clock_pin)
	);

	ppwdr_switch_model sw (
		.clk(mclk), .drv(drv), .oe_n(oe_n), .pu_en(pu), .sw_en(sw_en), .sw_lvl(sw_lvl),
		.pin(pin)
	);

	always #50 mclk = ~mclk;

	////////////////////////////////////////////////////////////////////////////////
	task automatic end_of_test();
		$display("Compared %0d, errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	always @(posedge mclk) begin
		cyc++;
		if (cyc == 10000) begin
			num_errors++;
			end_of_test();
		end
	end

	function automatic logic [7:0] ra(input int idx);
		return 8'(idx * 4);
	endfunction

	task automatic apb(input logic we, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= we;
		paddr   <= a;
		pwdata  <= d;
		@(posedge mclk);
		penable <= 1'b1;
		do begin
			@(posedge mclk);
		end while (pready !== 1'b1);
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input string nm);
		apb(1'b0, a, 32'h0);
		chk(nm, e, rd);
	endtask

	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		for (int p = 0; p < 4; p++) begin
			rdc(ra(REG_DIR + p), 32'hff, "dir");
			rdc(ra(REG_PU + p), 32'h00, "pullup");
		end
		rdc(ra(REG_DIR + PORT_E), 32'h0f, "dir_e");
		rdc(ra(REG_PU + PORT_E), 32'h00, "pullup_e");
		rdc(ra(REG_WAKE), 32'h00, "wake_en");
		rdc(ra(REG_SERIAL_PIN_LOCATION_LARGE), 32'h00, "serial_pin_location_large");
		rdc(ra(REG_IRQ_CLOCK_PIN_LOCATION_REG), 32'h00, "irq_clock_pin_location_reg");
		chk("oe_e", 32'h0f, 32'(oe_n[37:32]));
		wr(ra(REG_PU + PORT_E), 32'hff);
		rdc(ra(REG_PU + PORT_E), 32'h3f, "pullup_e");
		wr(ra(REG_DIR + PORT_E), 32'hff);
		rdc(ra(REG_DIR + PORT_E), 32'h3f, "dir_e");
		wr(ra(REG_WAKE), 32'ha5);
		rdc(ra(REG_WAKE), 32'ha5, "wake_en");
		// Port A half output, serial data out routed to A7
		serial_data_out <= 1'b1;
		sw_en[3:0] <= 4'hf;
		sw_lvl[3:0] <= 4'h3;
		wr(ra(REG_PU), 32'hff);
		wr(ra(REG_DATA), 32'h5a);
		wr(ra(REG_DIR), 32'h0f);
		repeat (4) @(posedge mclk);
		chk("pa_pullup", 32'h0f, 32'(pu[7:0]));
		chk("pa_oe_n", 32'h0f, 32'(oe_n[7:0]));
		chk("pa_out_hi", 32'hd, 32'(drv[7:4]));
		rdc(ra(REG_DATA), 32'h53, "pa_read");
		wr(ra(REG_SERIAL_PIN_LOCATION_LARGE), 32'h01);
		repeat (4) @(posedge mclk);
		chk("pa7_fallback", 32'h0, 32'(drv[7]));
		chk("pc0_sdo", 32'h1, 32'(drv[16]));
		wr(ra(REG_DIR), 32'hff);
		repeat (4) @(posedge mclk);
		rdc(ra(REG_DATA), 32'hf3, "pa_read_in");
		// Falls on enabled, masked and while running
		wr(ra(REG_WAKE), 32'h08);
		for (int k = 0; k < 3; k++) begin
			halted <= (k != 2);
			sw_lvl[3:0] <= 4'hf;
			repeat (6) @(posedge mclk);
			wk = 0;
			sw_lvl[3:0] <= (k == 1) ? 4'hb : 4'h7;
			repeat (8) begin
				@(posedge mclk);
				wk += int'(wake === 1'b1);
			end
			chk("wake_pulses", (k == 0) ? 32'h1 : 32'h0, 32'(wk));
		end
		// One-hot pin walk per selector code 0..2, all pins high for code 3
		sw_en <= {40{1'b1}};
		for (int c = 0; c < 4; c++) begin
			wr(ra(REG_SERIAL_PIN_LOCATION_LARGE), {24'h0, {4{2'(c)}}});
			wr(ra(REG_IRQ_CLOCK_PIN_LOCATION_REG), {24'h0, {4{c[0]}}, 2'(c), 2'(c)});
			for (int f = 0; f < 8; f++) begin
				sw_lvl <= (c == 3) ? {40{1'b1}} : 40'h1 << EXP[f][c % 3];
				repeat (5) @(posedge mclk);
				chk("func_route", (c == 3) ? 32'(f >= 3 && f <= 6) : 32'h1, 32'(fo[f]));
			end
		end
		// Peripheral clock: undefined code keeps the latch, code 0 takes B4
		chk("pb4_latch", 32'h1, 32'(drv[12]));
		wr(ra(REG_IRQ_CLOCK_PIN_LOCATION_REG), 32'h00);
		repeat (3) @(posedge mclk);
		chk("pb4_pck", 32'h0, 32'(drv[12]));
		periph_clock_pin <= 1'b1;
		repeat (3) @(posedge mclk);
		chk("pb4_pck", 32'h1, 32'(drv[12]));
		chk("slverr_ok", 32'h0, 32'(er));
		foreach (bad[i]) begin
			apb(1'b1, bad[i], 32'hff);
			chk("slverr", 32'h1, 32'(er));
		end
		rdc(8'h48, 32'h0, "unmapped");
		rdc(ra(REG_PU), 32'hff, "pullup_kept");
		srst <= 1'b1;
		repeat (16) @(posedge mclk);
		srst <= 1'b0;
		rdc(ra(REG_PU), 32'h0, "pullup_rst");
		rdc(ra(REG_DIR + PORT_E), 32'h0f, "dir_e_rst");
		end_of_test();
	end
endmodule // tb
